//--- dv/lcp_datapath_checker.sv
`timescale 1ns/10ps
`include "lcp_regs.svh"
module lcp_datapath_checker (
  input wire logic       clk_sys,
  input wire logic       reset_n,
  input wire logic [4:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic       bus_wr,
  input wire logic       bus_rd,
  input wire logic [7:0] bus_rdata,
  input wire logic [5:0] route_in,
  input wire logic [5:0] route_out,
  input wire logic [7:0] ctrl_out,
  input wire logic       chain_carry_out,
  input wire logic       chain_shift_out,
  input wire logic       chain_cond_out
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence s_ctrl_wr;
    bus_wr && bus_addr == `LCP_OFF_CTRL;
  endsequence
  sequence s_quiet;
    (route_in[5] && !bus_wr && !bus_rd)[*4];
  endsequence

  a_rdata_idle: assert property (!bus_rd |=> bus_rdata == 8'h00)
    else $error("read data outside read slot");
  a_unmapped_zero: assert property (bus_rd && bus_addr > `LCP_OFF_CLKCFG |=> bus_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_ctrl_write: assert property (s_ctrl_wr |=> ctrl_out == $past(bus_wdata))
    else $error("control write lost");
  a_ctrl_hold: assert property (!(bus_wr && bus_addr == `LCP_OFF_CTRL) |=> $stable(ctrl_out))
    else $error("control changed without write");
  a_shift_mirror: assert property (route_out[0] == chain_shift_out)
    else $error("serial out differs from chain");
  a_hold_carry: assert property (route_in[5] |=> $stable(chain_carry_out) && $stable(chain_shift_out))
    else $error("carry or shift moved in hold");
  a_quiet_conds: assert property (s_quiet |=> $stable(route_out) && $stable(chain_cond_out))
    else $error("conditions moved while quiet");
  a_reset_clear: assert property ($rose(reset_n) |-> ctrl_out == 8'h00 && bus_rdata == 8'h00)
    else $error("outputs not cleared by reset");
endmodule : lcp_datapath_checker

bind lcp_datapath lcp_datapath_checker u_checker (
  .clk_sys(clk_sys), .reset_n(reset_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
  .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .route_in(route_in),
  .route_out(route_out), .ctrl_out(ctrl_out), .chain_carry_out(chain_carry_out),
  .chain_shift_out(chain_shift_out), .chain_cond_out(chain_cond_out)
);

//--- dv/lcp_datapath_test.sv
`timescale 1ns/10ps
`include "lcp_regs.svh"
module lcp_datapath_test import lcp_pkg::*; ();
  logic        clk_sys   = 1'b0;
  logic        reset_n   = 1'b0;
  logic [4:0]  bus_addr  = 5'h00;
  logic [7:0]  bus_wdata = 8'h00;
  logic        bus_wr    = 1'b0;
  logic        bus_rd    = 1'b0;
  logic [7:0]  bus_rdata, ctrl_out, v, e;
  logic [5:0]  route_in, route_out, status_in;
  logic        c_cin, c_sin, c_kin, c_cout, c_sout, c_kout;
  logic [31:0] seed      = 32'hE16E;
  logic [7:0]  r [4];
  int          err_count, total_checks, m_acc0, m_acc1;
  int          q [$];

  always #20 clk_sys = ~clk_sys;

  lcp_datapath dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .route_in(route_in),
    .route_out(route_out), .status_in(status_in), .ctrl_out(ctrl_out), .chain_carry_in(c_cin),
    .chain_shift_in(c_sin), .chain_cond_in(c_kin), .chain_carry_out(c_cout),
    .chain_shift_out(c_sout), .chain_cond_out(c_kout)
  );
  lcp_fabric_model fab (
    .clk_sys(clk_sys), .route_in(route_in), .status_in(status_in),
    .chain_carry_in(c_cin), .chain_shift_in(c_sin), .chain_cond_in(c_kin)
  );

  function automatic logic [7:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction : rnd

  function automatic int alu(input int f, input int a, input int b);
    case (f)
      0: return (a + 1) & 255;
      1: return (a - 1) & 255;
      2: return (a + b) & 255;
      3: return (a - b) & 255;
      4: return a & b;
      5: return a | b;
      6: return a ^ b;
      default: return a;
    endcase
  endfunction : alu

  function automatic logic [15:0] cw(input int f, input logic [1:0] sb, input logic [1:0] sh, input logic [7:0] hi);
    return {hi, sh, sb, 1'b0, 3'(f)};
  endfunction : cw

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clk_sys);
    bus_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk_sys);
    bus_rd <= 1'b0;
    #1 d = bus_rdata;
  endtask : rd

  task automatic rdc(input logic [4:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    check(d, exp);
  endtask : rdc

  task automatic ldw(input int i, input logic [15:0] w);
    wr(`LCP_OFF_CFGPTR, 8'(i));
    wr(`LCP_OFF_CFGLO, w[7:0]);
    wr(`LCP_OFF_CFGHI, w[15:8]);
  endtask : ldw

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : idle

  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    finish_test();
  end

  initial begin
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    rdc(`LCP_OFF_AUX, `LCP_AUX_RST);
    rdc(`LCP_OFF_ANDMSK, `LCP_ANDMSK_RST);
    rdc(`LCP_OFF_CLKCFG, `LCP_CLKCFG_RST);
    wr(5'h1F, 8'hA5);
    rdc(5'h1F, 8'h00);
    v = rnd();
    wr(`LCP_OFF_CTRL, v);
    #1;
    check(ctrl_out, v);
    for (int i = 0; i < 4; i++) begin
      r[i] = rnd();
      wr(5'(i), r[i]);
    end
    for (int i = 0; i < 4; i++) begin
      rdc(5'(i), r[i]);
    end
    m_acc0 = r[0];
    for (int f = 0; f < 8; f++) begin
      ldw(f, cw(f, 2'd0, lcp_sh_none, 8'h01));
    end
    for (int f = 0; f < 8; f++) begin
      fab.step(3'(f), 1'b0);
      m_acc0 = alu(f, m_acc0, r[2]);
      rdc(`LCP_OFF_ACC0, 8'(m_acc0));
    end
    rdc(`LCP_OFF_OPR0, r[2]);
    // Narrow counter wraps at the programmed top bit
    wr(`LCP_OFF_AUX, 8'h18);
    wr(`LCP_OFF_ANDMSK, 8'h0F);
    wr(`LCP_OFF_ACC0, 8'h0F);
    fab.step(3'd0, 1'b0);
    rdc(`LCP_OFF_ACC0, 8'h00);
    check(8'(c_cout), 8'h01);
    wr(`LCP_OFF_AUX, `LCP_AUX_RST);
    wr(`LCP_OFF_ANDMSK, `LCP_ANDMSK_RST);
    v = rnd();
    wr(`LCP_OFF_ORMSK, v);
    ldw(1, cw(lcp_fn_pass, 2'd0, lcp_sh_swap, 8'h09));
    ldw(2, cw(lcp_fn_pass, 2'd0, lcp_sh_left, 8'h01));
    ldw(3, cw(lcp_fn_pass, 2'd0, lcp_sh_right, 8'h01));
    ldw(4, cw(lcp_fn_add, 2'd1, lcp_sh_none, 8'h02));
    e = rnd();
    wr(`LCP_OFF_ACC0, e);
    fab.step(3'd1, 1'b0);
    m_acc0 = {e[3:0], e[7:4]} | v;
    rdc(`LCP_OFF_ACC0, 8'(m_acc0));
    e = 8'((m_acc0 >> 7) & 1);
    fab.step(3'd2, 1'b1);
    m_acc0 = ((m_acc0 << 1) | 1) & 255;
    rdc(`LCP_OFF_ACC0, 8'(m_acc0));
    check(8'(c_sout), e);
    check(8'(route_out[0]), e);
    fab.step(3'd3, 1'b0);
    m_acc0 = m_acc0 >> 1;
    rdc(`LCP_OFF_ACC0, 8'(m_acc0));
    fab.step(3'd4, 1'b0);
    m_acc1 = (m_acc0 + r[3]) & 255;
    rdc(`LCP_OFF_ACC1, 8'(m_acc1));
    wr(`LCP_OFF_CLKCFG, 8'h04);
    fab.step(3'd4, 1'b0);
    rdc(`LCP_OFF_ACC1, 8'(m_acc1));
    wr(`LCP_OFF_CLKCFG, `LCP_CLKCFG_RST);
    // Queue zero as input buffer, overfilled then drained by the datapath
    wr(`LCP_OFF_OSEL, 8'h01);
    idle(3);
    check(8'(route_out[4:3]), 8'h01);
    for (int i = 0; i < 5; i++) begin
      v = rnd();
      wr(`LCP_OFF_QUEUE0, v);
      if (i < 4) q.push_back(v);
    end
    idle(3);
    check(8'(route_out[4:3]), 8'h02);
    rdc(`LCP_OFF_QUEUE0, 8'(q[0]));
    ldw(5, cw(lcp_fn_inc, 2'd0, lcp_sh_none, 8'h20));
    for (int i = 0; i < 4; i++) begin
      fab.step(3'd5, 1'b0);
      rdc(`LCP_OFF_OPR0, 8'(q.pop_front()));
    end
    idle(3);
    check(8'(route_out[4:3]), 8'h01);
    // Queue zero as output buffer, bus write refused
    wr(`LCP_OFF_AUX, 8'h39);
    wr(`LCP_OFF_QUEUE0, 8'hC3);
    ldw(6, cw(lcp_fn_pass, 2'd0, lcp_sh_none, 8'h40));
    for (int i = 0; i < 2; i++) begin
      v = rnd();
      wr(`LCP_OFF_ACC0, v);
      q.push_back(v);
      fab.step(3'd6, 1'b0);
    end
    for (int i = 0; i < 2; i++) begin
      rdc(`LCP_OFF_QUEUE0, 8'(q.pop_front()));
    end
    idle(3);
    check(8'(route_out[4:3]), 8'h01);
    // Compare match latched in status until read
    wr(`LCP_OFF_OPR0, r[2]);
    wr(`LCP_OFF_ACC0, r[2] ^ 8'h01);
    wr(`LCP_OFF_STMASK, 8'h01);
    fab.show(6'h2B);
    idle(3);
    rd(`LCP_OFF_STATUS, v);
    e = {6'h2B, 1'(m_acc1 < int'(r[3])), 1'b0};
    rdc(`LCP_OFF_STATUS, e);
    wr(`LCP_OFF_ACC0, r[2]);
    idle(3);
    check(8'(c_kout), 8'h01);
    wr(`LCP_OFF_ACC0, r[2] ^ 8'h01);
    idle(3);
    rdc(`LCP_OFF_STATUS, e | 8'h01);
    rdc(`LCP_OFF_STATUS, e);
    // One CRC step with the operand register as polynomial
    ldw(7, cw(lcp_fn_inc, 2'd0, lcp_sh_none, 8'h11));
    e = rnd();
    wr(`LCP_OFF_ACC0, e);
    fab.step(3'd7, 1'b0);
    m_acc0 = ((int'(e) << 1) & 255) ^ (e[7] ? int'(r[2]) : 0);
    rdc(`LCP_OFF_ACC0, 8'(m_acc0));
    finish_test();
  end
endmodule : lcp_datapath_test

//--- dv/lcp_fabric_model.sv
`timescale 1ns/10ps
module lcp_fabric_model (
  input  wire logic       clk_sys,
  output logic      [5:0] route_in,
  output logic      [5:0] status_in,
  output logic            chain_carry_in,
  output logic            chain_shift_in,
  output logic            chain_cond_in
);
  // Idle fabric holds the datapath, no neighbour attached
  initial begin
    route_in = 6'h20;
    status_in = 6'h00;
    chain_carry_in = 1'b0;
    chain_shift_in = 1'b0;
    chain_cond_in = 1'b0;
  end

  // One configuration index for one cycle, then hold again
  task automatic step(input logic [2:0] idx, input logic sdin);
    @(posedge clk_sys);
    route_in <= {2'b00, sdin, idx};
    @(posedge clk_sys);
    route_in <= 6'h20;
  endtask : step

  task automatic show(input logic [5:0] s);
    @(posedge clk_sys);
    status_in <= s;
  endtask : show
endmodule : lcp_fabric_model

//--- shared/lcp_pkg.sv
package lcp_pkg;
  typedef enum logic [2:0] {lcp_fn_inc, lcp_fn_dec, lcp_fn_add, lcp_fn_sub,
                            lcp_fn_and, lcp_fn_or, lcp_fn_xor, lcp_fn_pass} lcp_fn_t;
  typedef enum logic [1:0] {lcp_sh_none, lcp_sh_left, lcp_sh_right, lcp_sh_swap} lcp_shift_t;
  typedef enum logic [1:0] {lcp_ck_off, lcp_ck_run, lcp_ck_div, lcp_ck_ctrl} lcp_ckmode_t;
endpackage : lcp_pkg

//--- shared/lcp_regs.svh
`ifndef LCP_REGS_SVH
`define LCP_REGS_SVH

// Register offsets
`define LCP_OFF_ACC0    5'h00
`define LCP_OFF_ACC1    5'h01
`define LCP_OFF_OPR0    5'h02
`define LCP_OFF_OPR1    5'h03
`define LCP_OFF_QUEUE0  5'h04
`define LCP_OFF_QUEUE1  5'h05
`define LCP_OFF_CTRL    5'h06
`define LCP_OFF_STATUS  5'h07
`define LCP_OFF_STMASK  5'h08
`define LCP_OFF_CFGPTR  5'h09
`define LCP_OFF_CFGLO   5'h0A
`define LCP_OFF_CFGHI   5'h0B
`define LCP_OFF_AUX     5'h0C
`define LCP_OFF_ANDMSK  5'h0D
`define LCP_OFF_ORMSK   5'h0E
`define LCP_OFF_CMPMSK  5'h0F
`define LCP_OFF_OSEL    5'h10
`define LCP_OFF_CLKCFG  5'h11

// Configuration word fields
`define LCP_CW_FN       2:0
`define LCP_CW_SRCA     3
`define LCP_CW_SRCB     5:4
`define LCP_CW_SHIFT    7:6
`define LCP_CW_DEST0    8
`define LCP_CW_DEST1    9
`define LCP_CW_CIN      10
`define LCP_CW_ORM      11
`define LCP_CW_CRC      12
`define LCP_CW_FLOAD    13
`define LCP_CW_FCAP     14
`define LCP_CW_FSRC     15

// Auxiliary, output select and clock configuration fields
`define LCP_AUX_DIR0    0
`define LCP_AUX_CHAIN   2
`define LCP_AUX_MSB     5:3
`define LCP_OSEL_BANK   1:0
`define LCP_OSEL_C0A1   4
`define LCP_OSEL_C1A0   5
`define LCP_CLK_DP      1:0
`define LCP_CLK_SC      3:2

// Reset values and counts
`define LCP_AUX_RST     8'h38
`define LCP_ANDMSK_RST  8'hFF
`define LCP_CLKCFG_RST  8'h05
`define LCP_DIV_RATIO   4
`define LCP_FIFO_DEPTH  4

`endif

//--- verilog/lcp_alu.sv
`timescale 1ns/10ps
module lcp_alu import lcp_pkg::*; (
  input  wire logic [7:0] opa,
  input  wire logic [7:0] opb,
  input  wire lcp_fn_t    fn,
  input  wire lcp_shift_t shmode,
  input  wire logic       use_cin,
  input  wire logic       cin_ext,
  input  wire logic       shift_in,
  input  wire logic       crc_en,
  input  wire logic       crc_din,
  input  wire logic [2:0] msb,
  input  wire logic       orm_en,
  input  wire logic [7:0] orm,
  input  wire logic [7:0] andm,
  output logic      [7:0] res,
  output logic            cout,
  output logic            shout,
  output logic            ovf
);
  always_comb begin
    logic [7:0] wm, b2, r;
    logic [8:0] sum;
    logic       c, fb;
    wm = 8'hFF >> (3'h7 - msb);
    b2 = 8'h00;
    c  = 1'b0;
    r   = 8'h00;
    sum = 9'h000;
    fb  = 1'b0;
    case (fn)
      lcp_fn_inc: c = 1'b1;
      lcp_fn_dec: b2 = 8'hFF;
      lcp_fn_add: begin
        b2 = opb;
        c  = use_cin & cin_ext;
      end
      lcp_fn_sub: begin
        b2 = ~opb;
        c  = use_cin ? cin_ext : 1'b1;
      end
      default: b2 = 8'h00;
    endcase
    sum  = {1'b0, opa & wm} + {1'b0, b2 & wm} + {8'h00, c};
    cout = sum[4'(msb) + 4'h1];
    ovf  = (fn inside {lcp_fn_inc, lcp_fn_dec, lcp_fn_add, lcp_fn_sub}) &&
           (opa[msb] == b2[msb]) && (sum[msb] != opa[msb]);
    case (fn)
      lcp_fn_and:  r = opa & opb;
      lcp_fn_or:   r = opa | opb;
      lcp_fn_xor:  r = opa ^ opb;
      lcp_fn_pass: r = opa;
      default:     r = sum[7:0];
    endcase
    shout = 1'b0;
    case (shmode)
      lcp_sh_left: begin
        shout = r[msb];
        r     = {r[6:0], shift_in};
      end
      lcp_sh_right: begin
        shout  = r[0];
        r      = r >> 1;
        r[msb] = shift_in;
      end
      lcp_sh_swap: r = {r[3:0], r[7:4]};
      default:     r = r;
    endcase
    fb = opa[msb] ^ crc_din;
    if (crc_en) begin
      shout = opa[msb];
      r     = (opa << 1) ^ (fb ? opb : 8'h00);
    end
    if (orm_en) r = r | orm;
    res = r & andm;
  end
endmodule : lcp_alu

//--- verilog/lcp_datapath.sv
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/10ps
`include "lcp_regs.svh"

module lcp_datapath import lcp_pkg::*; #(
  parameter int DIV_RATIO  = `LCP_DIV_RATIO,
  parameter int FIFO_DEPTH = `LCP_FIFO_DEPTH
) (
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  input  wire logic [4:0] bus_addr,
  input  wire logic [7:0] bus_wdata,
  input  wire logic       bus_wr,
  input  wire logic       bus_rd,
  output logic      [7:0] bus_rdata,
  input  wire logic [5:0] route_in,
  output logic      [5:0] route_out,
  input  wire logic [5:0] status_in,
  output logic      [7:0] ctrl_out,
  input  wire logic       chain_carry_in,
  input  wire logic       chain_shift_in,
  input  wire logic       chain_cond_in,
  output logic            chain_carry_out,
  output logic            chain_shift_out,
  output logic            chain_cond_out
);
  localparam int DW = (DIV_RATIO > 1) ? $clog2(DIV_RATIO) : 1;

  // Working registers
  logic [7:0]  accumulator [2];
  logic [7:0]  next_acc    [2];
  logic [7:0]  operand_reg [2];
  logic [7:0]  next_opr    [2];
  logic        carry_q, next_carry;
  logic        shout_q, next_shout;
  logic        ovf_q, next_ovf;

  // Configuration store and software registers
  logic [15:0] cfg_mem      [8];
  logic [15:0] next_cfg_mem [8];
  logic [2:0]  cfg_ptr, next_cfg_ptr;
  logic [7:0]  aux, next_aux;
  logic [7:0]  andm, next_andm;
  logic [7:0]  orm, next_orm;
  logic [7:0]  cmpm, next_cmpm;
  logic [7:0]  osel, next_osel;
  logic [7:0]  clkcfg, next_clkcfg;
  logic [7:0]  stmask, next_stmask;
  logic [7:0]  sticky, next_sticky;
  logic [7:0]  next_ctrl, next_rdata;
  logic [5:0]  next_route;
  logic        next_cond;

  // Clock enables
  logic [DW-1:0] div_cnt, next_div_cnt;
  logic          div_tick, next_div_tick;
  logic          dp_ce, sc_ce, dp_go;

  // Queue ports
  logic [1:0]  f_push, f_pop, f_empty, f_full;
  logic [7:0]  f_wdata [2];
  logic [7:0]  f_q     [2];

  // ALU and condition signals
  logic [15:0] cw;
  logic [7:0]  opa, opb, alu_res;
  logic        alu_cout, alu_shout, alu_ovf;
  logic [7:0]  cmp0_b, cmp1_a;
  logic        cmp0, cmp1;
  logic [1:0]  zero, ones;
  logic [15:0] cond;
  logic [7:0]  st_src, st_view;

  function automatic logic lcp_ce(input logic [1:0] mode, input logic tick, input logic fw_en);
    case (lcp_ckmode_t'(mode))
      lcp_ck_run:  return 1'b1;
      lcp_ck_div:  return tick;
      lcp_ck_ctrl: return fw_en;
      default:     return 1'b0;
    endcase
  endfunction : lcp_ce

  // Divided enable shared by both subcomponents
  always_comb begin
    next_div_tick = 1'b0;
    next_div_cnt  = div_cnt + 1'b1;
    if (div_cnt == DW'(DIV_RATIO - 1)) begin
      next_div_cnt  = '0;
      next_div_tick = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      div_cnt  <= '0;
      div_tick <= 1'b0;
    end else begin
      div_cnt  <= next_div_cnt;
      div_tick <= next_div_tick;
    end
  end

  assign dp_ce = lcp_ce(clkcfg[`LCP_CLK_DP], div_tick, ctrl_out[7]);
  assign sc_ce = lcp_ce(clkcfg[`LCP_CLK_SC], div_tick, ctrl_out[7]);
  assign dp_go = dp_ce && !route_in[5];

  // Configuration word chosen by the routing each cycle
  assign cw  = cfg_mem[route_in[2:0]];
  assign opa = accumulator[cw[`LCP_CW_SRCA]];

  always_comb begin
    case (cw[`LCP_CW_SRCB])
      2'h0:    opb = operand_reg[0];
      2'h1:    opb = operand_reg[1];
      2'h2:    opb = accumulator[0];
      default: opb = accumulator[1];
    endcase
  end

  lcp_alu u_alu (
    .opa      (opa),
    .opb      (opb),
    .fn       (lcp_fn_t'(cw[`LCP_CW_FN])),
    .shmode   (lcp_shift_t'(cw[`LCP_CW_SHIFT])),
    .use_cin  (cw[`LCP_CW_CIN]),
    .cin_ext  (aux[`LCP_AUX_CHAIN] ? chain_carry_in : carry_q),
    .shift_in (aux[`LCP_AUX_CHAIN] ? chain_shift_in : (cw[`LCP_CW_CIN] ? shout_q : route_in[3])),
    .crc_en   (cw[`LCP_CW_CRC]),
    .crc_din  (route_in[4]),
    .msb      (aux[`LCP_AUX_MSB]),
    .orm_en   (cw[`LCP_CW_ORM]),
    .orm      (orm),
    .andm     (andm),
    .res      (alu_res),
    .cout     (alu_cout),
    .shout    (alu_shout),
    .ovf      (alu_ovf)
  );

  for (genvar gi = 0; gi < 2; gi++) begin : g_byte_queue
    lcp_fifo #(
      .WIDTH (8),
      .DEPTH (FIFO_DEPTH)
    ) u_queue (
      .clk_sys (clk_sys),
      .reset_n (reset_n),
      .push    (f_push[gi]),
      .wdata   (f_wdata[gi]),
      .pop     (f_pop[gi]),
      .rdata   (f_q[gi]),
      .empty   (f_empty[gi]),
      .full    (f_full[gi])
    );
    assign zero[gi] = (accumulator[gi] == 8'h00);
    assign ones[gi] = (accumulator[gi] == 8'hFF);
  end

  // Comparators
  assign cmp0_b = osel[`LCP_OSEL_C0A1] ? accumulator[1] : operand_reg[0];
  assign cmp1_a = osel[`LCP_OSEL_C1A0] ? accumulator[0] : accumulator[1];
  assign cmp0   = (((accumulator[0] ^ cmp0_b) & cmpm) == 8'h00) &&
                  (!aux[`LCP_AUX_CHAIN] || chain_cond_in);
  assign cmp1   = ((cmp1_a & cmpm) < (operand_reg[1] & cmpm));

  assign cond = {4'h0, carry_q, f_full[1], f_empty[1], f_full[0], f_empty[0],
                 ovf_q, ones[1], ones[0], zero[1], zero[0], cmp1, cmp0};

  // Datapath working state
  always_comb begin
    next_acc   = accumulator;
    next_opr   = operand_reg;
    next_carry = carry_q;
    next_shout = shout_q;
    next_ovf   = ovf_q;
    f_push     = 2'b00;
    f_pop      = 2'b00;
    if (dp_go) begin
      next_carry = alu_cout;
      next_shout = alu_shout;
      next_ovf   = alu_ovf;
      if (cw[`LCP_CW_DEST0]) next_acc[0] = alu_res;
      if (cw[`LCP_CW_DEST1]) next_acc[1] = alu_res;
    end
    for (int i = 0; i < 2; i++) begin
      f_wdata[i] = bus_wdata;
      if (aux[`LCP_AUX_DIR0 + i]) begin
        f_wdata[i] = cw[`LCP_CW_FSRC] ? accumulator[i] : alu_res;
        f_push[i]  = dp_go && cw[`LCP_CW_FCAP] && !f_full[i];
        f_pop[i]   = bus_rd && (bus_addr == 5'(`LCP_OFF_QUEUE0 + i));
      end else begin
        f_push[i] = bus_wr && (bus_addr == 5'(`LCP_OFF_QUEUE0 + i));
        f_pop[i]  = dp_go && cw[`LCP_CW_FLOAD] && !f_empty[i];
        if (f_pop[i]) begin
          if (cw[`LCP_CW_FSRC]) begin
            next_acc[i] = f_q[i];
          end else begin
            next_opr[i] = f_q[i];
          end
        end
      end
      if (bus_wr && (bus_addr == 5'(`LCP_OFF_ACC0 + i))) next_acc[i] = bus_wdata;
      if (bus_wr && (bus_addr == 5'(`LCP_OFF_OPR0 + i))) next_opr[i] = bus_wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      accumulator <= '{default: 8'h00};
      operand_reg <= '{default: 8'h00};
      carry_q     <= 1'b0;
      shout_q     <= 1'b0;
      ovf_q       <= 1'b0;
    end else begin
      accumulator <= next_acc;
      operand_reg <= next_opr;
      carry_q     <= next_carry;
      shout_q     <= next_shout;
      ovf_q       <= next_ovf;
    end
  end

  // Status sources and the value seen by a read
  assign st_src  = {status_in, cmp1, cmp0};
  assign st_view = (stmask & sticky) | (~stmask & st_src);

  // Software registers and read data
  always_comb begin
    next_ctrl    = ctrl_out;
    next_cfg_mem = cfg_mem;
    next_cfg_ptr = cfg_ptr;
    next_aux     = aux;
    next_andm    = andm;
    next_orm     = orm;
    next_cmpm    = cmpm;
    next_osel    = osel;
    next_clkcfg  = clkcfg;
    next_stmask  = stmask;
    next_sticky  = sticky;
    if (bus_rd && (bus_addr == `LCP_OFF_STATUS)) next_sticky = 8'h00;
    if (sc_ce) next_sticky = next_sticky | (st_src & stmask);
    if (bus_wr) begin
      case (bus_addr)
        `LCP_OFF_CTRL:   next_ctrl = bus_wdata;
        `LCP_OFF_STMASK: next_stmask = bus_wdata;
        `LCP_OFF_CFGPTR: next_cfg_ptr = bus_wdata[2:0];
        `LCP_OFF_CFGLO:  next_cfg_mem[cfg_ptr][7:0] = bus_wdata;
        `LCP_OFF_CFGHI:  next_cfg_mem[cfg_ptr][15:8] = bus_wdata;
        `LCP_OFF_AUX:    next_aux = bus_wdata;
        `LCP_OFF_ANDMSK: next_andm = bus_wdata;
        `LCP_OFF_ORMSK:  next_orm = bus_wdata;
        `LCP_OFF_CMPMSK: next_cmpm = bus_wdata;
        `LCP_OFF_OSEL:   next_osel = bus_wdata;
        `LCP_OFF_CLKCFG: next_clkcfg = bus_wdata;
        default:         next_ctrl = ctrl_out;
      endcase
    end
    next_rdata = 8'h00;
    if (bus_rd) begin
      case (bus_addr)
        `LCP_OFF_ACC0:       next_rdata = accumulator[0];
        `LCP_OFF_ACC1:       next_rdata = accumulator[1];
        `LCP_OFF_OPR0:       next_rdata = operand_reg[0];
        `LCP_OFF_OPR1:       next_rdata = operand_reg[1];
        `LCP_OFF_QUEUE0:     next_rdata = f_q[0];
        `LCP_OFF_QUEUE1:     next_rdata = f_q[1];
        `LCP_OFF_CTRL:       next_rdata = ctrl_out;
        `LCP_OFF_STATUS:     next_rdata = st_view;
        `LCP_OFF_STMASK:     next_rdata = stmask;
        `LCP_OFF_CFGPTR:     next_rdata = {5'h00, cfg_ptr};
        `LCP_OFF_CFGLO:      next_rdata = cfg_mem[cfg_ptr][7:0];
        `LCP_OFF_CFGHI:      next_rdata = cfg_mem[cfg_ptr][15:8];
        `LCP_OFF_AUX:        next_rdata = aux;
        `LCP_OFF_ANDMSK:     next_rdata = andm;
        `LCP_OFF_ORMSK:      next_rdata = orm;
        `LCP_OFF_CMPMSK:     next_rdata = cmpm;
        `LCP_OFF_OSEL:       next_rdata = osel;
        `LCP_OFF_CLKCFG:     next_rdata = clkcfg;
        default:             next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_out  <= 8'h00;
      cfg_mem   <= '{default: 16'h0000};
      cfg_ptr   <= 3'h0;
      aux       <= `LCP_AUX_RST;
      andm      <= `LCP_ANDMSK_RST;
      orm       <= 8'h00;
      cmpm      <= 8'hFF;
      osel      <= 8'h00;
      clkcfg    <= `LCP_CLKCFG_RST;
      stmask    <= 8'h00;
      sticky    <= 8'h00;
      bus_rdata <= 8'h00;
    end else begin
      ctrl_out  <= next_ctrl;
      cfg_mem   <= next_cfg_mem;
      cfg_ptr   <= next_cfg_ptr;
      aux       <= next_aux;
      andm      <= next_andm;
      orm       <= next_orm;
      cmpm      <= next_cmpm;
      osel      <= next_osel;
      clkcfg    <= next_clkcfg;
      stmask    <= next_stmask;
      sticky    <= next_sticky;
      bus_rdata <= next_rdata;
    end
  end

  // Routing and chaining outputs
  always_comb begin
    case (osel[`LCP_OSEL_BANK])
      2'h0:    next_route = {cond[4:0], next_shout};
      2'h1:    next_route = {cond[9:5], next_shout};
      2'h2:    next_route = {cond[14:10], next_shout};
      default: next_route = {5'h00, next_shout};
    endcase
    next_cond = cmp0;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      route_out      <= 6'h00;
      chain_cond_out <= 1'b0;
    end else begin
      route_out      <= next_route;
      chain_cond_out <= next_cond;
    end
  end

  assign chain_carry_out = carry_q;
  assign chain_shift_out = shout_q;
endmodule : lcp_datapath

//--- verilog/lcp_fifo.sv
`timescale 1ns/10ps
module lcp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  input  wire logic             push,
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic             pop,
  output logic      [WIDTH-1:0] rdata,
  output logic                  empty,
  output logic                  full
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    rptr, next_rptr, wptr, next_wptr;
  logic [PW:0]      cnt, next_cnt;
  logic             do_push, do_pop;

  assign rdata = mem[rptr];
  assign empty = (cnt == '0);
  assign full  = (cnt == (PW+1)'(DEPTH));

  always_comb begin
    do_push   = push && !full;
    do_pop    = pop && !empty;
    next_wptr = wptr;
    next_rptr = rptr;
    if (do_push) next_wptr = (wptr == PW'(DEPTH-1)) ? '0 : wptr + 1'b1;
    if (do_pop)  next_rptr = (rptr == PW'(DEPTH-1)) ? '0 : rptr + 1'b1;
    next_cnt = cnt + (PW+1)'(do_push) - (PW+1)'(do_pop);
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rptr <= '0;
      wptr <= '0;
      cnt  <= '0;
    end else begin
      rptr <= next_rptr;
      wptr <= next_wptr;
      cnt  <= next_cnt;
      if (do_push) mem[wptr] <= wdata;
    end
  end
endmodule : lcp_fifo
